// >>> sfp_arr.sv
// Array model that accepts bytes and reports operation completion.
`timescale 1ns/1ps
module sfp_arr
    import sfp_pkg::*;
(
    input wire logic clk,
    input wire logic hang,
    output logic arr_wr_ready,
    input wire sfp_op_req_t arr_op,
    output logic arr_done
);
    logic [3:0] n_q = 4'h0;
    // Ready drops one cycle in four so the buffer really sees stalls.
    assign arr_wr_ready = n_q[1:0] != 2'h0;
    always_ff @(posedge clk) begin
        n_q <= n_q + 4'h1;
        // A hung array never reports completion, forcing a timeout.
        arr_done <= !hang && arr_op.valid;
    end
endmodule

// >>> sfp_ctrl.sv
// Program and erase sequencer of a serial NOR flash, from the serial pins to the array port.
//
// Behaviour
// - Program accepted only with write enable latch set.
// - Self-timed program starts on chip select rise.
// - Command, address, data bytes; bits on rising clock.
// - Data past page end wraps to page start.
// - Only last page-size bytes kept; others untouched.
// - Busy bit high while program or erase runs.
// - Starting an operation clears the write enable latch.
// - Program timeout clears latch, sets program error.
// - Misframed chip select: nothing runs, latch kept.
// - Protected program: no run, bits 1 and 4.
// - Dual data variants on two lines, not quad.
// - Quad data variants on four lines, not dual.
// - Suspend pauses and resume continues the operation.
// - Code 06h sets the write enable latch.
// - Enable codes on one, two, four lines.
// - Every program or erase needs latch set.
// - Misframed write enable leaves latch at zero.
// - Code 04h clears the write enable latch.
// - Erase sets addressed subsector or sector to FFh.
// - Erase without latch ignored, no error flags.
// - Erase timeout clears latch, sets erase error.
// - Protected erase: no run, bits 1 and 5.
`timescale 1ns/1ps
module sfp_ctrl
    import sfp_pkg::*;
#(
    parameter int PAGE = 256,
    parameter int NUM_SECT = 512,
    parameter int SECT_SHIFT = 16,
    parameter int SUB_SHIFT = 12,
    parameter int FIFO_D = 2,
    parameter logic [7:0] CMD_PP = 8'hA1,
    parameter logic [7:0] CMD_DIFP = 8'hA2,
    parameter logic [7:0] CMD_EDIFP = 8'hA3,
    parameter logic [7:0] CMD_QIFP = 8'hA4,
    parameter logic [7:0] CMD_EQIFP = 8'hA5,
    parameter logic [7:0] CMD_SSE = 8'hA6,
    parameter logic [7:0] CMD_SE = 8'hA7,
    parameter logic [7:0] CMD_SUS = 8'hA8,
    parameter logic [7:0] CMD_RES = 8'hA9,
    parameter int PROG_TIME_NS = 2000,
    parameter int SSE_TIME_NS = 4000,
    parameter int SE_TIME_NS = 8000,
    parameter int TIMEOUT_NS = 400000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic [3:0] spi_dq,
    input wire sfp_proto_t proto_mode,
    input wire logic four_byte_mode,
    input wire logic [NUM_SECT-1:0] sector_lock,
    input wire logic flag_clear,
    output sfp_wr_t arr_wr,
    output logic arr_wr_valid,
    input wire logic arr_wr_ready,
    output sfp_op_req_t arr_op,
    output logic arr_suspend,
    input wire logic arr_done,
    output logic status_wip,
    output logic status_wel,
    output sfp_flags_t flags
);
    localparam int PAGE_W = $clog2(PAGE);
    localparam int SIDX_W = $clog2(NUM_SECT);
    localparam int AW = `SFP_ADDR_W;
    localparam int TW = `SFP_TIMER_W;
    localparam logic [TW-1:0] PROG_CYC = TW'((PROG_TIME_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS);
    localparam logic [TW-1:0] SSE_CYC = TW'((SSE_TIME_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS);
    localparam logic [TW-1:0] SE_CYC = TW'((SE_TIME_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS);
    localparam logic [TW-1:0] TMO_CYC = TW'(TIMEOUT_NS / `SFP_CLK_NS);
    localparam logic [PAGE_W-1:0] LAST_COL = PAGE_W'(PAGE - 1);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic sfp_kind_t decode(input logic [7:0] code);
        sfp_kind_t k;
        k = k_none;
        if (code == `SFP_CMD_WREN) k = k_wren;
        else if (code == `SFP_CMD_WRDI) k = k_wrdi;
        else if (code == CMD_PP) k = k_pp;
        else if (code == CMD_DIFP) k = k_difp;
        else if (code == CMD_EDIFP) k = k_edifp;
        else if (code == CMD_QIFP) k = k_qifp;
        else if (code == CMD_EQIFP) k = k_eqifp;
        else if (code == CMD_SSE) k = k_sse;
        else if (code == CMD_SE) k = k_se;
        else if (code == CMD_SUS) k = k_sus;
        else if (code == CMD_RES) k = k_res;
        return k;
    endfunction

    function automatic logic [2:0] proto_lanes(input sfp_proto_t p);
        logic [2:0] w;
        w = `SFP_LANE1;
        if (p == sfp_dual) w = `SFP_LANE2;
        else if (p == sfp_quad) w = `SFP_LANE4;
        return w;
    endfunction

    // Phase 0 is the command byte, 1 the address, 2 the data.
    function automatic logic [2:0] lanes(input sfp_proto_t p, input sfp_kind_t k, input logic [1:0] ph);
        logic [2:0] w;
        w = proto_lanes(p);
        if (p == sfp_ext && ph == 2'h1) begin
            if (k == k_edifp) w = `SFP_LANE2;
            else if (k == k_eqifp) w = `SFP_LANE4;
            else w = `SFP_LANE1;
        end else if (p == sfp_ext && ph == 2'h2) begin
            if (k == k_difp || k == k_edifp) w = `SFP_LANE2;
            else if (k == k_qifp || k == k_eqifp) w = `SFP_LANE4;
            else w = `SFP_LANE1;
        end
        return w;
    endfunction

    function automatic logic prog_ok(input sfp_proto_t p, input sfp_kind_t k);
        logic ok;
        ok = 1'b0;
        case (k)
            k_pp: ok = 1'b1;
            k_difp, k_edifp: ok = (p != sfp_quad);
            k_qifp, k_eqifp: ok = (p != sfp_dual);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // A bit only moves once the second and third stages agree, so a single glitch sample is dropped.
    logic [5:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
    logic sck_prev_q, cs_prev_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_s1_q <= `SFP_PIN_RST;
            pin_s2_q <= `SFP_PIN_RST;
            pin_s3_q <= `SFP_PIN_RST;
            pin_f_q <= `SFP_PIN_RST;
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            pin_s1_q <= {spi_cs_n, spi_sck, spi_dq};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_f_q <= (pin_f_q & (pin_s2_q ^ pin_s3_q)) | (pin_s3_q & ~(pin_s2_q ^ pin_s3_q));
            sck_prev_q <= pin_f_q[4];
            cs_prev_q <= pin_f_q[5];
        end
    end
    logic cs_n_f, sck_rise, cs_rise, cs_fall;
    logic [3:0] dq_f;
    assign cs_n_f = pin_f_q[5];
    assign dq_f = pin_f_q[3:0];
    assign sck_rise = pin_f_q[4] & ~sck_prev_q;
    assign cs_rise = cs_n_f & ~cs_prev_q;
    assign cs_fall = ~cs_n_f & cs_prev_q;

    // ****************************************************************
    // Frame deserialiser
    // ****************************************************************
    logic [7:0] sh_q, sh_d;
    logic [3:0] cnt_q, cnt_d;
    logic [2:0] bidx_q, nab, lane_w;
    logic [1:0] phase;
    logic got_data_q, byte_done;
    sfp_kind_t kind_q;
    logic [AW-1:0] addr_q;
    sfp_state_t st_q;
    assign nab = four_byte_mode ? `SFP_NAB4 : `SFP_NAB3;
    assign phase = (bidx_q == 3'h0) ? 2'h0 : ((bidx_q <= nab) ? 2'h1 : 2'h2);
    assign lane_w = lanes(proto_mode, kind_q, phase);
    always_comb begin
        case (lane_w)
            `SFP_LANE2: sh_d = {sh_q[5:0], dq_f[1:0]};
            `SFP_LANE4: sh_d = {sh_q[3:0], dq_f};
            default: sh_d = {sh_q[6:0], dq_f[0]};
        endcase
    end
    assign cnt_d = cnt_q + {1'b0, lane_w};
    assign byte_done = sck_rise & ~cs_n_f & (cnt_d == `SFP_BYTE_BITS);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            bidx_q <= 3'h0;
            got_data_q <= 1'b0;
            kind_q <= k_none;
            addr_q <= '0;
        end else if (cs_n_f) begin
            cnt_q <= 4'h0;
            bidx_q <= 3'h0;
            got_data_q <= 1'b0;
        end else if (sck_rise) begin
            sh_q <= sh_d;
            cnt_q <= byte_done ? 4'h0 : cnt_d;
            if (byte_done) begin
                if (phase == 2'h0) kind_q <= decode(sh_d);
                else if (phase == 2'h1) addr_q <= {addr_q[AW-9:0], sh_d};
                else got_data_q <= 1'b1;
                if (phase != 2'h2) bidx_q <= bidx_q + 3'h1;
            end
        end
    end

    // ****************************************************************
    // Page buffer
    // ****************************************************************
    logic [7:0] page_q [PAGE];
    logic [PAGE-1:0] mask_q;
    logic [PAGE_W-1:0] col_q, idx_q;
    logic [AW+7:0] addr_ext;
    logic xfer_end, wr_byte;
    assign addr_ext = {addr_q, sh_d};
    assign wr_byte = byte_done & (phase == 2'h2) & (st_q == st_idle);
    always_ff @(posedge clk) begin
        if (wr_byte) page_q[col_q] <= sh_d;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_q <= '0;
            col_q <= '0;
        end else begin
            if ((cs_fall && st_q == st_idle) || xfer_end) mask_q <= '0;
            else if (wr_byte) mask_q[col_q] <= 1'b1;
            if (byte_done && phase == 2'h1 && bidx_q == nab) col_q <= addr_ext[PAGE_W-1:0];
            else if (wr_byte) col_q <= col_q + 1'b1;
        end
    end

    // ****************************************************************
    // Frame evaluation at chip select rise
    // ****************************************************************
    logic aligned, cmd_only, addr_done, locked, wel_q;
    logic ev_wren, ev_wrdi, ev_sus, ev_res, ev_prog_try, ev_prog_go, ev_prot_p;
    logic ev_erase_try, ev_erase_go, ev_prot_e, ev_done, ev_tmo;
    logic idle;
    assign idle = (st_q == st_idle);
    assign aligned = (cnt_q == 4'h0);
    assign cmd_only = aligned & (bidx_q == 3'h1);
    assign addr_done = aligned & (bidx_q == nab + 3'h1) & ~got_data_q;
    assign locked = sector_lock[addr_q[SECT_SHIFT +: SIDX_W]];
    assign ev_wren = cs_rise & idle & cmd_only & (kind_q == k_wren);
    assign ev_wrdi = cs_rise & idle & cmd_only & (kind_q == k_wrdi);
    assign ev_sus = cs_rise & (st_q == st_busy) & cmd_only & (kind_q == k_sus);
    assign ev_res = cs_rise & (st_q == st_susp) & cmd_only & (kind_q == k_res);
    assign ev_prog_try = cs_rise & idle & aligned & got_data_q & prog_ok(proto_mode, kind_q) & wel_q;
    assign ev_prot_p = ev_prog_try & locked;
    assign ev_prog_go = ev_prog_try & ~locked;
    assign ev_erase_try = cs_rise & idle & addr_done & (kind_q == k_sse || kind_q == k_se) & wel_q;
    assign ev_prot_e = ev_erase_try & locked;
    assign ev_erase_go = ev_erase_try & ~locked;

    // ****************************************************************
    // Two-entry buffer towards the array
    // ****************************************************************
    // Entry 0 is the head, so the array port is driven straight from flops.
    sfp_wr_t fifo_q [FIFO_D];
    logic [FIFO_D-1:0] fvld_q;
    logic push, pop, fifo_rdy;
    sfp_wr_t fifo_in;
    sfp_op_t op_q;
    logic [AW-1:0] op_addr_q;
    assign fifo_rdy = ~fvld_q[FIFO_D-1];
    assign pop = fvld_q[0] & arr_wr_ready;
    assign push = (st_q == st_xfer) & mask_q[idx_q] & fifo_rdy;
    assign fifo_in = '{addr: {op_addr_q[AW-1:PAGE_W], idx_q}, data: page_q[idx_q]};
    genvar gi;
    generate
        for (gi = 0; gi < FIFO_D; gi++) begin : g_fifo
            logic slot_hit;
            if (gi == 0) begin : g_first
                assign slot_hit = pop ? ~fvld_q[1] : ~fvld_q[0];
            end else if (gi == FIFO_D - 1) begin : g_last
                assign slot_hit = pop ? 1'b0 : (fvld_q[gi-1] & ~fvld_q[gi]);
            end else begin : g_mid
                assign slot_hit = pop ? (fvld_q[gi] & ~fvld_q[gi+1]) : (fvld_q[gi-1] & ~fvld_q[gi]);
            end
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    fifo_q[gi] <= '0;
                    fvld_q[gi] <= 1'b0;
                end else if (push && slot_hit) begin
                    fifo_q[gi] <= fifo_in;
                    fvld_q[gi] <= 1'b1;
                end else if (pop) begin
                    fifo_q[gi] <= (gi == FIFO_D - 1) ? '0 : fifo_q[(gi + 1) % FIFO_D];
                    fvld_q[gi] <= (gi == FIFO_D - 1) ? 1'b0 : fvld_q[(gi + 1) % FIFO_D];
                end
            end
        end
    endgenerate
    assign arr_wr = fifo_q[0];
    assign arr_wr_valid = fvld_q[0];

    // ****************************************************************
    // Operation sequencer
    // ****************************************************************
    logic [TW-1:0] timer_q, dur;
    logic done_seen_q;
    assign dur = (op_q == op_prog) ? PROG_CYC : ((op_q == op_sse) ? SSE_CYC : SE_CYC);
    assign xfer_end = (st_q == st_xfer) & (idx_q == LAST_COL) & (~mask_q[idx_q] | fifo_rdy);
    assign ev_done = (st_q == st_busy) & (timer_q >= dur) & (done_seen_q | arr_done) & ~fvld_q[0];
    assign ev_tmo = (st_q == st_busy) & ~ev_done & (timer_q >= TMO_CYC);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= st_idle;
            idx_q <= '0;
            timer_q <= '0;
            done_seen_q <= 1'b0;
            op_q <= op_prog;
            op_addr_q <= '0;
        end else begin
            case (st_q)
                st_idle: begin
                    timer_q <= '0;
                    done_seen_q <= 1'b0;
                    idx_q <= '0;
                    if (ev_prog_go) begin
                        st_q <= st_xfer;
                        op_q <= op_prog;
                        op_addr_q <= addr_q;
                    end else if (ev_erase_go) begin
                        st_q <= st_busy;
                        op_q <= (kind_q == k_sse) ? op_sse : op_se;
                        op_addr_q <= (kind_q == k_sse) ? {addr_q[AW-1:SUB_SHIFT], {SUB_SHIFT{1'b0}}}
                                                       : {addr_q[AW-1:SECT_SHIFT], {SECT_SHIFT{1'b0}}};
                    end
                end
                st_xfer: begin
                    if (xfer_end) st_q <= st_busy;
                    else if (~mask_q[idx_q] | fifo_rdy) idx_q <= idx_q + 1'b1;
                end
                st_busy: begin
                    timer_q <= timer_q + 1'b1;
                    if (arr_done) done_seen_q <= 1'b1;
                    if (ev_done || ev_tmo) st_q <= st_idle;
                    else if (ev_sus) st_q <= st_susp;
                end
                st_susp: begin
                    if (arr_done) done_seen_q <= 1'b1;
                    if (ev_res) st_q <= st_busy;
                end
                default: st_q <= st_idle;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            arr_op <= '0;
        end else begin
            arr_op.valid <= ((st_q == st_idle) && ev_erase_go) || xfer_end;
            if (xfer_end) begin
                arr_op.op <= op_prog;
                arr_op.addr <= op_addr_q;
            end else if (ev_erase_go) begin
                arr_op.op <= (kind_q == k_sse) ? op_sse : op_se;
                arr_op.addr <= (kind_q == k_sse) ? {addr_q[AW-1:SUB_SHIFT], {SUB_SHIFT{1'b0}}}
                                                 : {addr_q[AW-1:SECT_SHIFT], {SECT_SHIFT{1'b0}}};
            end
        end
    end

    // ****************************************************************
    // Status and flags
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) status_wip <= 1'b0;
        else if (ev_prog_go || ev_erase_go) status_wip <= 1'b1;
        else if (ev_done || ev_tmo) status_wip <= 1'b0;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) wel_q <= `SFP_WEL_RST;
        else if (ev_prog_go || ev_erase_go || ev_tmo) wel_q <= 1'b0;
        else if (ev_wren) wel_q <= 1'b1;
        else if (ev_wrdi) wel_q <= 1'b0;
    end
    assign status_wel = wel_q;
    // A hardware set in the same cycle as a software clear wins.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags <= '0;
        end else begin
            if (ev_prot_p || ev_prot_e) flags.prot_err <= 1'b1;
            else if (flag_clear) flags.prot_err <= 1'b0;
            if (ev_prot_p || (ev_tmo && op_q == op_prog)) flags.prog_err <= 1'b1;
            else if (flag_clear) flags.prog_err <= 1'b0;
            if (ev_prot_e || (ev_tmo && op_q != op_prog)) flags.erase_err <= 1'b1;
            else if (flag_clear) flags.erase_err <= 1'b0;
            if (ev_sus) begin
                flags.prog_susp <= (op_q == op_prog);
                flags.erase_susp <= (op_q != op_prog);
                flags.suspended <= 1'b1;
            end else if (ev_res || ev_done) begin
                flags.prog_susp <= 1'b0;
                flags.erase_susp <= 1'b0;
                flags.suspended <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) arr_suspend <= 1'b0;
        else if (ev_sus) arr_suspend <= 1'b1;
        else if (ev_res) arr_suspend <= 1'b0;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_go;
        ev_prog_go || ev_erase_go;
    endsequence
    sequence s_prot;
        ev_prot_p;
    endsequence
    property p_wel_clear;
        @(posedge clk) disable iff (!resetn) s_go |=> !status_wel && status_wip;
    endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared at start");
    property p_wip_state;
        @(posedge clk) disable iff (!resetn) status_wip == (st_q != st_idle);
    endproperty
    a_wip_state: assert property (p_wip_state) else $error("busy bit disagrees with state");
    property p_prot_prog;
        @(posedge clk) disable iff (!resetn) s_prot |=> flags.prot_err && flags.prog_err && status_wel && !status_wip;
    endproperty
    a_prot_prog: assert property (p_prot_prog) else $error("protected program mishandled");
    property p_prot_erase;
        @(posedge clk) disable iff (!resetn) ev_prot_e |=> flags.prot_err && flags.erase_err && status_wel;
    endproperty
    a_prot_erase: assert property (p_prot_erase) else $error("protected erase mishandled");
    property p_tmo;
        @(posedge clk) disable iff (!resetn) ev_tmo |=> !status_wel && (flags.prog_err || flags.erase_err);
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout not reported");
    property p_no_wel_go;
        @(posedge clk) disable iff (!resetn) (cs_rise && !wel_q && idle) |=> st_q == st_idle && $stable(flags.erase_err);
    endproperty
    a_no_wel_go: assert property (p_no_wel_go) else $error("operation started without latch");
    property p_wren;
        @(posedge clk) disable iff (!resetn) ev_wren |=> status_wel;
    endproperty
    a_wren: assert property (p_wren) else $error("write enable did not set latch");
    property p_wrdi;
        @(posedge clk) disable iff (!resetn) ev_wrdi |=> !status_wel;
    endproperty
    a_wrdi: assert property (p_wrdi) else $error("write disable did not clear latch");
    property p_misframe;
        @(posedge clk) disable iff (!resetn) (cs_rise && !aligned) |=> $stable(status_wel) && $stable(st_q);
    endproperty
    a_misframe: assert property (p_misframe) else $error("misframed command acted");
    property p_wrap;
        @(posedge clk) disable iff (!resetn) (wr_byte && col_q == LAST_COL) |=> col_q == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("column did not wrap");
endmodule

// >>> sfp_map.svh
// Command codes, widths, reset values and timing constants of the program and erase controller.
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
`define SFP_CMD_WREN 8'h06
`define SFP_CMD_WRDI 8'h04
`define SFP_ADDR_W 32
`define SFP_CLK_NS 4
`define SFP_LANE1 3'h1
`define SFP_LANE2 3'h2
`define SFP_LANE4 3'h4
`define SFP_BYTE_BITS 4'h8
`define SFP_NAB3 3'h3
`define SFP_NAB4 3'h4
`define SFP_PIN_RST 6'h20
`define SFP_WEL_RST 1'b0
`define SFP_TIMER_W 32
`endif

// >>> sfp_pkg.sv
// Types shared by the program and erase controller.
`include "sfp_map.svh"
package sfp_pkg;
    typedef enum logic [1:0] {
        sfp_ext = 2'b00,
        sfp_dual = 2'b01,
        sfp_quad = 2'b10
    } sfp_proto_t;
    typedef enum logic [3:0] {
        k_none = 4'b0000,
        k_wren = 4'b0001,
        k_wrdi = 4'b0010,
        k_pp = 4'b0011,
        k_difp = 4'b0100,
        k_edifp = 4'b0101,
        k_qifp = 4'b0110,
        k_eqifp = 4'b0111,
        k_sse = 4'b1000,
        k_se = 4'b1001,
        k_sus = 4'b1010,
        k_res = 4'b1011
    } sfp_kind_t;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_xfer = 2'b01,
        st_busy = 2'b10,
        st_susp = 2'b11
    } sfp_state_t;
    typedef enum logic [1:0] {
        op_prog = 2'b00,
        op_sse = 2'b01,
        op_se = 2'b10
    } sfp_op_t;
    typedef struct packed {
        logic [`SFP_ADDR_W-1:0] addr;
        logic [7:0] data;
    } sfp_wr_t;
    typedef struct packed {
        logic valid;
        sfp_op_t op;
        logic [`SFP_ADDR_W-1:0] addr;
    } sfp_op_req_t;
    typedef struct packed {
        logic prot_err;
        logic prog_err;
        logic erase_err;
        logic prog_susp;
        logic erase_susp;
        logic suspended;
    } sfp_flags_t;
endpackage

// >>> testbench.sv
// Self-checking bench for the program and erase controller.
`timescale 1ns/1ps
module testbench;
    import sfp_pkg::*;
    logic clk = 0, resetn = 0, cs_n = 1, sck = 0, fc = 0, hang = 0, rdy, done, wip, wel, wv, sp;
    sfp_proto_t pm = sfp_ext;
    int lw = 1;
    logic [3:0] dq = 4'h0;
    logic [511:0] lock = '0;
    logic [31:0] oa;
    logic [39:0] wa[$];
    sfp_wr_t wr;
    sfp_op_req_t op;
    sfp_flags_t fl;
    int err_total = 0, tests_run = 0, cyc = 0;
    always #2 clk = ~clk;
    sfp_ctrl #(.PROG_TIME_NS(40), .SSE_TIME_NS(80), .SE_TIME_NS(120), .TIMEOUT_NS(2000)) dut_u (
        .clk(clk), .resetn(resetn), .spi_cs_n(cs_n), .spi_sck(sck), .spi_dq(dq), .proto_mode(pm),
        .four_byte_mode(1'b0), .sector_lock(lock), .flag_clear(fc), .arr_wr(wr), .arr_wr_valid(wv),
        .arr_wr_ready(rdy), .arr_op(op), .arr_suspend(sp), .arr_done(done), .status_wip(wip),
        .status_wel(wel), .flags(fl));
    sfp_arr arr_u (.clk(clk), .hang(hang), .arr_wr_ready(rdy), .arr_op(op), .arr_done(done));
    always @(posedge clk) begin
        if (wv && rdy)
            wa.push_back(wr);
        if (op.valid)
            oa <= op.addr;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task chk_a(input logic [39:0] g, input logic [39:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_b(input logic g, input logic e);
        chk_a({39'h0, g}, {39'h0, e});
    endtask
    task ck(input int n);
        repeat (n) @(negedge clk);
    endtask
    task wt;
        for (int i = 0; i < 1500 && wip !== 1'h0; i++) ck(1);
    endtask
    // Sends the bytes MSB first on lw lines; the last byte may be cut short.
    task frm(input logic [7:0] q[$], input int nb);
        cs_n = 0;
        ck(3);
        foreach (q[i]) begin
            for (int k = 7; k > 7 - (i == q.size() - 1 ? nb : 8); k -= lw) begin
                dq = 4'(q[i] >> (k + 1 - lw));
                ck(6);
                sck = 1;
                ck(6);
                sck = 0;
            end
        end
        ck(3);
        cs_n = 1;
        ck(12);
    endtask
    task t_wel;
        frm('{8'h06}, 7);
        chk_b(wel, 1'h0);
        frm('{8'h06}, 8);
        chk_b(wel, 1'h1);
        frm('{8'h04}, 8);
        chk_b(wel, 1'h0);
        frm('{8'hA7, 8'h01, 8'h00, 8'h00}, 8);
        chk_b(wip, 1'h0);
        $display("t_wel done");
    endtask
    task t_prog;
        frm('{8'h06}, 8);
        wa = {};
        frm('{8'hA1, 8'h00, 8'h00, 8'hFE, 8'hAA, 8'hBB, 8'hCC}, 8);
        chk_b(wip, 1'h1);
        chk_b(wel, 1'h0);
        wt();
        wa.sort();
        chk_a(wa.size(), 40'h3);
        chk_a(wa[0], 40'h00CC);
        chk_a(wa[1], 40'hFEAA);
        chk_a(wa[2], 40'hFFBB);
        chk_b(wip, 1'h0);
        $display("t_prog done");
    endtask
    task t_err;
        lock[0] = 1;
        frm('{8'h06}, 8);
        frm('{8'hA6, 8'h00, 8'h10, 8'h00}, 8);
        chk_b(wel, 1'h1);
        chk_b(fl.prot_err && fl.erase_err, 1'h1);
        lock[0] = 0;
        hang = 1;
        fc = 1;
        frm('{8'h06}, 8);
        fc = 0;
        frm('{8'hA7, 8'h01, 8'h23, 8'h45}, 8);
        chk_a(oa, 40'h10000);
        frm('{8'hA8}, 8);
        chk_b(sp && fl.suspended && fl.erase_susp && wip, 1'h1);
        frm('{8'hA9}, 8);
        chk_b(sp || fl.suspended, 1'h0);
        wt();
        chk_b(fl.erase_err && !wel, 1'h1);
        $display("t_err done");
    endtask
    task t_mode;
        pm = sfp_dual;
        lw = 2;
        frm('{8'h06}, 8);
        chk_b(wel, 1'h1);
        frm('{8'hA4, 8'h00, 8'h00, 8'h10, 8'h55}, 8);
        chk_b(wip || !wel, 1'h0);
        lock[0] = 1;
        frm('{8'hA1, 8'h00, 8'h00, 8'h10, 8'h55}, 8);
        chk_b(fl.prot_err && fl.prog_err && wel && !wip, 1'h1);
        lock[0] = 0;
        frm('{8'h04}, 8);
        chk_b(wel, 1'h0);
        pm = sfp_ext;
        lw = 1;
        $display("t_mode done");
    endtask
    task end_sim;
        $display("tests %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        ck(12);
        resetn = 1;
        ck(4);
        t_wel();
        t_prog();
        t_mode();
        t_err();
        end_sim();
    end
endmodule
